// ### logic/mnfsm_pkg.sv
package mnfsm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] FLAGS_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] STATE_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 5'h0C;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 5'h10;

  localparam int CTRL_CMD_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  // Flag register field positions
  localparam int FLG_DECEL_UV = 0;
  localparam int FLG_HARD_UV = 1;
  localparam int FLG_ANY_UV = 2;
  localparam int FLG_SUPPLY_RST = 3;
  localparam int FLG_THERMAL_SD = 4;
  localparam int FLG_ELEC_FAULT = 5;
  localparam int FLG_ELEC_DEFECT = 6;
  localparam int FLG_TINFO_LSB = 8;

  // Values after reset
  localparam logic UV_RST = 1'b0;
  localparam logic SUPPLY_RST_RST = 1'b1;
  localparam logic THERMAL_SD_RST = 1'b0;

  // Temperature information codes
  localparam logic [1:0] TINFO_NORMAL = 2'h0;
  localparam logic [1:0] TINFO_SHUTDOWN = 2'h3;

  // Interrupt status and mask layout
  localparam int IRQ_W = 4;
  localparam int IRQ_UV = 0;
  localparam int IRQ_THERMAL = 1;
  localparam int IRQ_RECOVER = 2;
  localparam int IRQ_RESPONSE = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  typedef enum logic [10:0] {
    ST_STANDBY = 11'h001,
    ST_STOPPED = 11'h002,
    ST_MOVING_TO_TARGET = 11'h004,
    ST_DUAL_POSITION = 11'h008,
    ST_DECELERATING = 11'h010,
    ST_FORCED_STOP = 11'h020,
    ST_DECEL_DONE = 11'h040,
    ST_SHUTDOWN = 11'h080,
    ST_SLEEP = 11'h100,
    ST_UNDERVOLTAGE_FORCED = 11'h200,
    ST_UNDERVOLTAGE_OFF = 11'h400
  } mnfsm_state_t;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_READ_POSITION = 3'h1,
    CMD_READ_OTP_PARAM = 3'h2,
    CMD_READ_SHORT_STATUS = 3'h3,
    CMD_READ_FULL_STATUS = 3'h4,
    CMD_OTHER = 3'h5
  } mnfsm_cmd_code_t;

  typedef struct packed {
    logic valid;
    mnfsm_cmd_code_t code;
  } mnfsm_cmd_t;

  typedef struct packed {
    logic valid;
    mnfsm_cmd_code_t code;
  } mnfsm_resp_t;

  typedef struct packed {
    logic valid;
    mnfsm_state_t target;
  } mnfsm_mot_req_t;

  typedef struct packed {
    logic vbb_le_decel;
    logic vbb_le_hard;
    logic vbb_le_lowest;
    logic [1:0] tinfo;
  } mnfsm_sense_t;

endpackage : mnfsm_pkg

// ### logic/mnfsm_sync.sv
`timescale 1ns/10ps
module mnfsm_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;

  // First stage feeds the second stage only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule : mnfsm_sync

// ### logic/mnfsm_sticky.sv
`timescale 1ns/10ps
module mnfsm_sticky #(
  parameter logic RST = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic set,
  input wire logic clr,
  output logic flag_d,
  output logic flag_q
);
  // Set wins over a clear in the same cycle
  always_comb
  begin
    flag_d = flag_q;
    if (ce)
      flag_d = set | (flag_q & ~clr);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_q <= RST;
    else
      flag_q <= flag_d;
  end
endmodule : mnfsm_sticky

// ### logic/mnfsm_top.sv
// Overview of operation
// - Decel-stop undervoltage flag set at threshold, resets 0
// - Hard-stop undervoltage flag set at threshold, resets 0
// - Undervoltage flags clear on status header above lowest
// - Overall undervoltage flag is OR of both
// - Supply-reset flag set on power-up, cleared by status
// - Controller keeps eleven states, hold current, bridge off
// - Position and OTP reads answered except in decel done or sleep, state kept
// - Status read answers except in decel done, sleep, undervoltage off; standby/shutdown recover when clear
// - Electrical flag ORs hard undervoltage, defect, supply-reset
// - Thermal flag clears on status read, normal temperature
`timescale 1ns/10ps
module mnfsm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [mnfsm_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mnfsm_pkg::mnfsm_sense_t sense,
  input wire logic electrical_defect,
  input wire mnfsm_pkg::mnfsm_cmd_t cmd,
  input wire mnfsm_pkg::mnfsm_mot_req_t mot_req,
  output mnfsm_pkg::mnfsm_resp_t resp,
  output mnfsm_pkg::mnfsm_state_t state,
  output logic decel_stop_undervoltage_flag,
  output logic hard_stop_undervoltage_flag,
  output logic any_undervoltage_flag,
  output logic electrical_fault_flag,
  output logic thermal_shutdown_flag,
  output logic supply_reset_flag,
  output logic hold_current_en,
  output logic bridge_hiz,
  output logic irq
);
  import mnfsm_pkg::*;

  // ----------------------------------------------------------------
  // Sensor inputs
  // ----------------------------------------------------------------
  mnfsm_sense_t sns_s;
  logic [$bits(mnfsm_sense_t)-1:0] sns_raw;

  // Comparators and thermal sensor are analog, hence asynchronous
  mnfsm_sync #(.W($bits(mnfsm_sense_t))) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(sense),
    .q(sns_raw)
  );
  assign sns_s = mnfsm_sense_t'(sns_raw);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  mnfsm_state_t state_q, state_d;
  mnfsm_resp_t resp_q, resp_d;
  logic cmd_fire, is_status, is_read, hdr, serve, read_ok, status_ok;

  assign cmd_fire = ce & cmd.valid & ctrl_q[CTRL_CMD_EN_BIT];
  assign is_status = (cmd.code == CMD_READ_SHORT_STATUS) | (cmd.code == CMD_READ_FULL_STATUS);
  assign is_read = (cmd.code == CMD_READ_POSITION) | (cmd.code == CMD_READ_OTP_PARAM);
  // No answer while decel done or asleep
  assign read_ok = (state_q != ST_DECEL_DONE) & (state_q != ST_SLEEP);
  assign status_ok = read_ok & (state_q != ST_UNDERVOLTAGE_OFF);
  // Header alone is enough to release undervoltage flags
  assign hdr = cmd_fire & is_status;
  assign serve = hdr & status_ok;

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  logic uv3_d, uv3_q, uv2_d, uv2_q, vdd_d, vdd_q, tsd_d, tsd_q;
  logic uv_clr, hs_d;

  assign uv_clr = hdr & ~sns_s.vbb_le_lowest;

  mnfsm_sticky #(.RST(UV_RST)) u_uv3 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set(sns_s.vbb_le_decel),
    .clr(uv_clr),
    .flag_d(uv3_d),
    .flag_q(uv3_q)
  );

  mnfsm_sticky #(.RST(UV_RST)) u_uv2 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set(sns_s.vbb_le_hard),
    .clr(uv_clr),
    .flag_d(uv2_d),
    .flag_q(uv2_q)
  );

  // Reset value carries the power-up indication
  mnfsm_sticky #(.RST(SUPPLY_RST_RST)) u_vdd (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set(1'b0),
    .clr(serve),
    .flag_d(vdd_d),
    .flag_q(vdd_q)
  );

  mnfsm_sticky #(.RST(THERMAL_SD_RST)) u_tsd (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set(sns_s.tinfo == TINFO_SHUTDOWN),
    .clr(serve & (sns_s.tinfo == TINFO_NORMAL)),
    .flag_d(tsd_d),
    .flag_q(tsd_q)
  );

  assign any_undervoltage_flag = uv2_q | uv3_q;
  assign electrical_fault_flag = uv2_q | electrical_defect | vdd_q;
  // Post-clear view used for the recovery decision
  assign hs_d = uv2_d | electrical_defect | vdd_d;
  assign decel_stop_undervoltage_flag = uv3_q;
  assign hard_stop_undervoltage_flag = uv2_q;
  assign thermal_shutdown_flag = tsd_q;
  assign supply_reset_flag = vdd_q;

  // ----------------------------------------------------------------
  // Main controller
  // ----------------------------------------------------------------
  logic recover;

  assign recover = serve & ((state_q == ST_STANDBY) | (state_q == ST_SHUTDOWN))
                   & ~tsd_d & ~hs_d;

  always_comb
  begin
    state_d = state_q;
    resp_d = '0;
    if (cmd_fire)
    begin
      resp_d.code = cmd.code;
      resp_d.valid = (is_read & read_ok) | (is_status & status_ok);
      if (recover)
        state_d = ST_STOPPED;
    end
    else if (ce & mot_req.valid)
    begin
      // Motion sequencer owns all other transitions
      unique case (mot_req.target)
        ST_STANDBY, ST_STOPPED, ST_MOVING_TO_TARGET, ST_DUAL_POSITION,
        ST_DECELERATING, ST_FORCED_STOP, ST_DECEL_DONE, ST_SHUTDOWN,
        ST_SLEEP, ST_UNDERVOLTAGE_FORCED, ST_UNDERVOLTAGE_OFF:
          state_d = mot_req.target;
        default:
          state_d = state_q;
      endcase
    end
    if (!ce)
      resp_d = resp_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_STANDBY;
      resp_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      resp_q <= resp_d;
    end
  end

  assign state = state_q;
  assign resp = resp_q;
  assign hold_current_en = (state_q == ST_STOPPED);
  assign bridge_hiz = (state_q == ST_SHUTDOWN);

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, ev;

  always_comb
  begin
    ev = '0;
    ev[IRQ_UV] = (uv2_d | uv3_d) & ~any_undervoltage_flag;
    ev[IRQ_THERMAL] = tsd_d & ~tsd_q;
    ev[IRQ_RECOVER] = cmd_fire & recover;
    ev[IRQ_RESPONSE] = ce & resp_d.valid;
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [31:0] prdata_q, prdata_d, rd_mux;
  logic rdy_q, rdy_d, access, done, mapped, wr_ctrl, wr_mask, rd_stat;

  assign access = psel & penable;
  // Reads wait one captured cycle so clear-on-read never loses an event
  assign pready = ce & (pwrite | rdy_q);
  assign done = access & pready;
  assign mapped = (paddr == CTRL_OFS) | (paddr == FLAGS_OFS) | (paddr == STATE_OFS)
                  | (paddr == IRQ_STAT_OFS) | (paddr == IRQ_MASK_OFS);
  assign pslverr = access & ~mapped;
  assign prdata = prdata_q;
  assign wr_ctrl = done & pwrite & (paddr == CTRL_OFS) & pstrb[0];
  assign wr_mask = done & pwrite & (paddr == IRQ_MASK_OFS) & pstrb[0];
  assign rd_stat = done & ~pwrite & (paddr == IRQ_STAT_OFS);

  always_comb
  begin
    rd_mux = '0;
    unique case (paddr)
      CTRL_OFS: rd_mux = ctrl_q;
      FLAGS_OFS:
      begin
        rd_mux[FLG_DECEL_UV] = uv3_q;
        rd_mux[FLG_HARD_UV] = uv2_q;
        rd_mux[FLG_ANY_UV] = any_undervoltage_flag;
        rd_mux[FLG_SUPPLY_RST] = vdd_q;
        rd_mux[FLG_THERMAL_SD] = tsd_q;
        rd_mux[FLG_ELEC_FAULT] = electrical_fault_flag;
        rd_mux[FLG_ELEC_DEFECT] = electrical_defect;
        rd_mux[FLG_TINFO_LSB +: 2] = sns_s.tinfo;
      end
      STATE_OFS: rd_mux[10:0] = state_q;
      IRQ_STAT_OFS: rd_mux[IRQ_W-1:0] = irq_stat_q;
      IRQ_MASK_OFS: rd_mux[IRQ_W-1:0] = irq_mask_q;
      default: rd_mux = '0;
    endcase
  end

  always_comb
  begin
    prdata_d = prdata_q;
    rdy_d = rdy_q;
    ctrl_d = ctrl_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    if (done)
      rdy_d = 1'b0;
    else if (psel & ce & ~pwrite)
    begin
      rdy_d = 1'b1;
      prdata_d = rd_mux;
    end
    if (wr_ctrl)
      ctrl_d = {24'h00_0000, pwdata[7:0]};
    if (wr_mask)
      irq_mask_d = pwdata[IRQ_W-1:0];
    // Only bits the master actually saw are cleared; new events win
    if (rd_stat)
      irq_stat_d = irq_stat_q & ~prdata_q[IRQ_W-1:0];
    irq_stat_d = irq_stat_d | ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= '0;
      rdy_q <= 1'b0;
      ctrl_q <= CTRL_RST;
      irq_mask_q <= IRQ_MASK_RST;
      irq_stat_q <= '0;
    end
    else
    begin
      prdata_q <= prdata_d;
      rdy_q <= rdy_d;
      ctrl_q <= ctrl_d;
      irq_mask_q <= irq_mask_d;
      irq_stat_q <= irq_stat_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_UV3_SET: assert property (ce && sns_s.vbb_le_decel |=> uv3_q)
    else $error("decel undervoltage flag not set");

  AST_UV2_SET: assert property (ce && sns_s.vbb_le_hard |=> uv2_q)
    else $error("hard undervoltage flag not set");

  AST_UV_HOLD: assert property (uv2_q && !uv_clr |=> uv2_q)
    else $error("hard undervoltage flag dropped without clear");

  AST_UV_FALL: assert property ($fell(any_undervoltage_flag) |-> $past(uv_clr))
    else $error("overall undervoltage flag fell without status header");

  AST_VDD_CLR: assert property (serve && !electrical_defect |=> !vdd_q ##1 !vdd_q)
    else $error("supply reset flag not cleared by status read");

  AST_ONEHOT: assert property ($onehot(state_q) && !(hold_current_en && bridge_hiz))
    else $error("controller state not one-hot");

  AST_READ_RESP: assert property (cmd_fire && is_read && read_ok
    |=> resp_q.valid && state_q == $past(state_q))
    else $error("position or parameter read not answered");

  AST_RECOVER: assert property (recover |=> state_q == ST_STOPPED && resp_q.valid)
    else $error("status read did not recover to stopped");

  AST_HS_BLOCK: assert property (serve && hs_d
    && (state_q == ST_STANDBY || state_q == ST_SHUTDOWN) |=> state_q == $past(state_q))
    else $error("left standby with electrical flag set");

  AST_TSD_FALL: assert property ($fell(tsd_q)
    |-> $past(serve) && $past(sns_s.tinfo) == TINFO_NORMAL)
    else $error("thermal flag cleared without status read");

  AST_UV3_HOLD: assert property (uv3_q && !uv_clr |=> uv3_q)
    else $error("decel undervoltage flag dropped without clear");

  AST_ANY_UV_SET: assert property (ce && (sns_s.vbb_le_decel || sns_s.vbb_le_hard)
    |=> any_undervoltage_flag)
    else $error("overall undervoltage flag not set");

  AST_VDD_STAY: assert property (vdd_q && !serve |=> vdd_q)
    else $error("supply reset flag dropped without status read");

  AST_PARKED_QUIET: assert property (cmd_fire && !read_ok
    |=> !resp_q.valid && state_q == $past(state_q))
    else $error("answer given while decel done or asleep");

  AST_TSD_SET: assert property (ce && sns_s.tinfo == TINFO_SHUTDOWN |=> tsd_q)
    else $error("thermal flag not set at shutdown code");

endmodule : mnfsm_top

// ### dv/mnfsm_lin_master.sv
`timescale 1ns/10ps
// ------------------------------
// Bus master issuing frame heads
// ------------------------------
module mnfsm_lin_master (
  input wire logic pclk,
  input wire mnfsm_pkg::mnfsm_resp_t resp,
  output mnfsm_pkg::mnfsm_cmd_t cmd
);
  import mnfsm_pkg::*;

  initial cmd = '0;

  // One header pulse, then the answer slot is sampled mid-cycle to stay race free
  task automatic send(input mnfsm_cmd_code_t c, output mnfsm_resp_t r);
    @(posedge pclk);
    cmd <= '{1'b1, c};
    @(posedge pclk);
    cmd <= '0;
    @(negedge pclk);
    r = resp;
  endtask : send
endmodule : mnfsm_lin_master

// ### dv/tb.sv
`timescale 1ns/10ps
module tb;
  import mnfsm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  mnfsm_sense_t sense = '0;
  logic electrical_defect = 1'b0;
  mnfsm_cmd_t cmd;
  mnfsm_mot_req_t mot_req = '0;
  mnfsm_resp_t resp;
  mnfsm_resp_t r;
  mnfsm_state_t state;
  logic f_dec, f_hard, f_any, f_elec, f_th, f_sup, hold_en, hiz, irq;
  wire [5:0] flg = {f_sup, f_th, f_elec, f_any, f_hard, f_dec};
  int failures = 0;
  int total_checks = 0;

  always #10 pclk = ~pclk;

  mnfsm_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense(sense), .electrical_defect(electrical_defect),
    .cmd(cmd), .mot_req(mot_req), .resp(resp), .state(state),
    .decel_stop_undervoltage_flag(f_dec), .hard_stop_undervoltage_flag(f_hard),
    .any_undervoltage_flag(f_any), .electrical_fault_flag(f_elec),
    .thermal_shutdown_flag(f_th), .supply_reset_flag(f_sup), .hold_current_en(hold_en),
    .bridge_hiz(hiz), .irq(irq));

  mnfsm_lin_master i_master (.pclk(pclk), .resp(resp), .cmd(cmd));

  // ----------------
  // Helpers
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // pready and prdata are taken at the edge, before that edge's own updates land
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb

  // Two synchroniser stages plus the flag register
  task automatic sn(input mnfsm_sense_t s);
    @(posedge pclk);
    sense <= s;
    repeat (4) @(negedge pclk);
  endtask : sn

  task automatic mv(input mnfsm_state_t t);
    @(posedge pclk);
    mot_req <= '{1'b1, t};
    @(posedge pclk);
    mot_req <= '0;
    @(negedge pclk);
  endtask : mv

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset;
    chk(state, ST_STANDBY);
    chk(flg, 6'h28);
    apb(1'b0, CTRL_OFS, '0);
    chk(rd, CTRL_RST);
    apb(1'b0, IRQ_MASK_OFS, '0);
    chk(rd, 32'h0);
    apb(1'b0, 5'h14, '0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
  endtask : t_reset

  task automatic t_refuse;
    apb(1'b1, CTRL_OFS, 32'h0);
    i_master.send(CMD_READ_SHORT_STATUS, r);
    chk({r.valid, f_sup, state}, {2'b01, ST_STANDBY});
    apb(1'b1, CTRL_OFS, 32'h1);
    // A frozen clock enable must swallow the header and keep the supply-reset flag
    @(posedge pclk);
    ce <= 1'b0;
    i_master.send(CMD_READ_SHORT_STATUS, r);
    chk({r.valid, f_sup, state}, {2'b01, ST_STANDBY});
    @(posedge pclk);
    ce <= 1'b1;
  endtask : t_refuse

  task automatic t_status;
    apb(1'b1, IRQ_MASK_OFS, 32'hC);
    i_master.send(CMD_READ_SHORT_STATUS, r);
    chk(r, {1'b1, CMD_READ_SHORT_STATUS});
    chk(flg, 6'h0);
    chk({state, hold_en, irq}, {ST_STOPPED, 2'b11});
    apb(1'b0, IRQ_STAT_OFS, '0);
    chk(rd, 32'hC);
    chk(irq, 1'b0);
  endtask : t_status

  task automatic t_pos;
    mnfsm_cmd_code_t c[2] = '{CMD_READ_POSITION, CMD_READ_OTP_PARAM};
    foreach (c[i])
    begin
      i_master.send(c[i], r);
      chk({r, state}, {1'b1, c[i], ST_STOPPED});
    end
  endtask : t_pos

  task automatic t_uv;
    sn('{1'b1, 1'b0, 1'b1, 2'h0});
    chk(flg, 6'h05);
    sn('{1'b1, 1'b1, 1'b1, 2'h0});
    chk(flg, 6'h0F);
    apb(1'b0, FLAGS_OFS, '0);
    chk(rd, 32'h27);
    sn('{1'b0, 1'b0, 1'b1, 2'h0});
    i_master.send(CMD_READ_FULL_STATUS, r);
    chk(flg, 6'h0F);
    sn('0);
    i_master.send(CMD_READ_FULL_STATUS, r);
    chk(flg, 6'h0);
  endtask : t_uv

  task automatic t_thermal;
    sn('{1'b0, 1'b0, 1'b0, TINFO_SHUTDOWN});
    i_master.send(CMD_READ_SHORT_STATUS, r);
    chk(f_th, 1'b1);
    sn('0);
    i_master.send(CMD_READ_SHORT_STATUS, r);
    chk(f_th, 1'b0);
  endtask : t_thermal

  // A defect keeps the node parked until it goes away
  task automatic t_recover;
    mv(ST_SHUTDOWN);
    chk({hiz, hold_en}, 2'b10);
    @(posedge pclk);
    electrical_defect <= 1'b1;
    i_master.send(CMD_READ_FULL_STATUS, r);
    chk({r.valid, state}, {1'b1, ST_SHUTDOWN});
    @(posedge pclk);
    electrical_defect <= 1'b0;
    i_master.send(CMD_READ_FULL_STATUS, r);
    chk(state, ST_STOPPED);
    mv(ST_DECEL_DONE);
    i_master.send(CMD_READ_POSITION, r);
    chk({r.valid, state}, {1'b0, ST_DECEL_DONE});
    mv(ST_UNDERVOLTAGE_OFF);
    i_master.send(CMD_READ_SHORT_STATUS, r);
    chk({r.valid, state}, {1'b0, ST_UNDERVOLTAGE_OFF});
    apb(1'b0, STATE_OFS, '0);
    chk(rd, {21'h0, ST_UNDERVOLTAGE_OFF});
  endtask : t_recover

  task automatic conclude;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    #200000;
    failures++;
    conclude();
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset();
    t_refuse();
    t_status();
    t_pos();
    t_uv();
    t_thermal();
    t_recover();
    conclude();
  end
endmodule : tb
